// ===== src/cmeb_top.sv
/*
 * Channel mask and event bank: receive channel mask, interrupt event
 * register with mask, small control registers and the overlong-cycle
 * watch, all behind an AXI4-Lite slave.
 * Assumes event sources come from logic on clk, except the two
 * general-purpose interrupt pins, which are asynchronous.
 */
`timescale 1ns/1ps

// Notes on behaviour
// (RL1) Bit n of the 32-bit channel mask enables receive on channel n.
// (RL2) Ones written at 78h set mask bits; ones at 7Ch clear them.
// (RL3) Reading either channel mask offset returns the current mask.
// (RL4) Event bits set on source rising edge or software one at 80h.
// (RL5) Only a one written at 84h clears an event bit.
// (RL6) Event reads return stored events ANDed with the interrupt mask.
// (RL7) Event bits 31 and 28 always read zero and ignore writes.
// (RL8) Bit 30 sets when an enabled general-purpose interrupt input asserts.
// (RL9) Bit 29 is software only, no hardware source.
// (RL10) With late-ack enable, bit 27 sets on FIFO data, busy unit or tardy ack.
// (RL11) Bit 26 sets when a PHY byte arrives; byte readable in bits 23-16.
// (RL12) As cycle master, bit 25 sets when a cycle exceeds 125 us.
// (RL13) The overlong cycle event clears the cycle-master enable bit 21.
// (RL14) Bit 24 sets when an error stops a subunit.
// (RL15) While bit 24 is set, events of the failed contexts cannot set from hardware sources; a one at 80h still sets them.
// (RL16) Bit 23 sets when a received cycle start disagrees with the timer.
// (RL17) Event bits 31, 28 and 15-10 come out of reset as zero.
// (RL18) Zeros written at set or clear offsets change nothing.
module cmeb_top #(
    parameter int CYCLE_LIMIT = cmeb_pkg::CYCLE_LIMIT_CYC,
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Event sources
    input wire logic gp_irq_upper_pin,
    input wire logic gp_irq_lower_pin,
    input wire logic rx_fifo_pending,
    input wire logic phys_resp_busy,
    input wire logic ack_tardy_sent,
    input wire logic phy_byte_valid,
    input wire logic [7:0] phy_byte,
    input wire logic cycle_start_tx,
    input wire logic subaction_gap_end,
    input wire logic subunit_dead,
    input wire logic [31:0] failed_ctx_events,
    input wire logic rx_cycle_start,
    input wire logic [6:0] rx_seconds,
    input wire logic [12:0] rx_count,
    // Block outputs
    output logic [31:0] rx_channel_enable,
    output logic timing_root_enable,
    output logic late_ack_report_enable,
    output logic irq
);
    import cmeb_pkg::*;

    typedef struct packed {
        logic [31:0] chan;
        logic [31:0] evt;
        logic [31:0] imask;
        logic late_en;
        logic root_en;
        logic gp_up_en;
        logic gp_lo_en;
        logic [31:0] tmr;
        logic [7:0] phy_byte;
        logic [31:0] src_prev;
        logic [1:0] gp_meta;
        logic [1:0] gp_sync;
        cmeb_cyc_t cyc_st;
        logic [CNT_W-1:0] cyc_cnt;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
    } cmeb_state_t;

    cmeb_state_t s_q;
    cmeb_state_t s_d;

    logic [31:0] src;
    logic [31:0] rise;
    logic [31:0] hw_set;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] wdat;
    logic wr_go;
    logic rd_go;
    logic ov_hit;
    logic mismatch;
    logic [32:0] rd_word;

    // Byte strobes to a bit mask
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Read decode: error flag above the data word
    function automatic logic [32:0] read_reg(input logic [7:0] a, input cmeb_state_t s);
        logic [31:0] d;
        logic err;
        d = 32'h0000_0000;
        err = 1'b0;
        case (a)
            // (RL3) both offsets read mask
            OFF_CHAN_SET, OFF_CHAN_CLR: begin
                d = s.chan;
            end
            // (RL6) masked event read
            OFF_EVT_SET, OFF_EVT_CLR: begin
                d = s.evt & s.imask;
            end
            OFF_IMASK_SET, OFF_IMASK_CLR: begin
                d = s.imask;
            end
            OFF_HCC_SET, OFF_HCC_CLR: begin
                d[HCC_LATE_ACK_BIT] = s.late_en;
            end
            OFF_LCTL_SET, OFF_LCTL_CLR: begin
                d[LCTL_ROOT_BIT] = s.root_en;
            end
            // (RL11) PHY byte readback
            OFF_PHYCTL: begin
                d[PHY_BYTE_LSB +: 8] = s.phy_byte;
            end
            OFF_TIMER: begin
                d = s.tmr;
            end
            OFF_GPCTL: begin
                d[GP_UPPER_BIT] = s.gp_up_en;
                d[GP_LOWER_BIT] = s.gp_lo_en;
            end
            default: begin
                err = 1'b1;
            end
        endcase
        return {err, d};
    endfunction

    // (RL9) event sources, bit 29 has none
    always_comb begin
        wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
        rd_go = s_axi_arvalid && s_q.arready;
        wdat = s_q.w_data & strb_mask(s_q.w_strb);
        rd_word = read_reg(s_axi_araddr, s_q);
        // (RL12) cycle exceeds limit
        ov_hit = (s_q.cyc_st == CMEB_CYC_RUN) && !subaction_gap_end
            && (s_q.cyc_cnt == CNT_W'(CYCLE_LIMIT));
        // (RL16) received cycle start compare
        mismatch = rx_cycle_start
            && ((rx_seconds != s_q.tmr[TMR_SEC_LSB +: 7])
            || (rx_count != s_q.tmr[TMR_CNT_LSB +: 13]));
        src = 32'h0000_0000;
        // (RL8) gated general-purpose inputs
        src[EVT_GP] = (s_q.gp_sync[1] && s_q.gp_up_en) || (s_q.gp_sync[0] && s_q.gp_lo_en);
        // (RL10) late acknowledge sources
        src[EVT_LATE_ACK] = s_q.late_en && (rx_fifo_pending || phys_resp_busy || ack_tardy_sent);
        src[EVT_PHY_BYTE] = phy_byte_valid;
        src[EVT_OVERLONG] = ov_hit;
        // (RL14) subunit stopped
        src[EVT_FATAL] = subunit_dead;
        src[EVT_MISMATCH] = mismatch;
        // (RL4) rising edge sets
        rise = src & ~s_q.src_prev;
        hw_set = rise;
        // (RL15) block failed contexts
        if (s_q.evt[EVT_FATAL]) begin
            hw_set = rise & ~(failed_ctx_events & ~(32'h1 << EVT_FATAL));
        end
        sw_set = 32'h0000_0000;
        sw_clr = 32'h0000_0000;
        if (wr_go && s_q.aw_addr == OFF_EVT_SET) begin
            sw_set = wdat;
        end
        if (wr_go && s_q.aw_addr == OFF_EVT_CLR) begin
            sw_clr = wdat;
        end
    end

    // Next state
    always_comb begin
        s_d = s_q;
        s_d.src_prev = src;
        s_d.gp_meta = {gp_irq_upper_pin, gp_irq_lower_pin};
        s_d.gp_sync = s_q.gp_meta;
        if (phy_byte_valid) begin
            s_d.phy_byte = phy_byte;
        end
        // Write address and data capture
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // (RL18) register writes; zeros at set or clear offsets change nothing
        if (wr_go) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (s_q.aw_addr)
                // (RL2) set and clear mask
                OFF_CHAN_SET: begin
                    s_d.chan = s_q.chan | wdat;
                end
                OFF_CHAN_CLR: begin
                    s_d.chan = s_q.chan & ~wdat;
                end
                OFF_EVT_SET, OFF_EVT_CLR, OFF_PHYCTL: begin
                    s_d.bresp = RESP_OKAY;
                end
                OFF_IMASK_SET: begin
                    s_d.imask = s_q.imask | wdat;
                end
                OFF_IMASK_CLR: begin
                    s_d.imask = s_q.imask & ~wdat;
                end
                OFF_HCC_SET: begin
                    s_d.late_en = s_q.late_en | wdat[HCC_LATE_ACK_BIT];
                end
                OFF_HCC_CLR: begin
                    s_d.late_en = s_q.late_en & ~wdat[HCC_LATE_ACK_BIT];
                end
                OFF_LCTL_SET: begin
                    s_d.root_en = s_q.root_en | wdat[LCTL_ROOT_BIT];
                end
                OFF_LCTL_CLR: begin
                    s_d.root_en = s_q.root_en & ~wdat[LCTL_ROOT_BIT];
                end
                OFF_TIMER: begin
                    s_d.tmr = (s_q.tmr & ~strb_mask(s_q.w_strb)) | wdat;
                end
                OFF_GPCTL: begin
                    if (s_q.w_strb[3]) begin
                        s_d.gp_up_en = s_q.w_data[GP_UPPER_BIT];
                    end
                    if (s_q.w_strb[2]) begin
                        s_d.gp_lo_en = s_q.w_data[GP_LOWER_BIT];
                    end
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        s_d.awready = !s_d.aw_have;
        s_d.wready = !s_d.w_have;
        // (RL5) clear only by software; (RL7) reserved bits held at zero
        s_d.evt = ((s_q.evt & ~sw_clr) | sw_set | hw_set) & EVT_IMPL;
        // Overlong cycle watch
        case (s_q.cyc_st)
            CMEB_CYC_IDLE: begin
                s_d.cyc_cnt = '0;
                if (s_q.root_en && cycle_start_tx) begin
                    s_d.cyc_st = CMEB_CYC_RUN;
                end
            end
            CMEB_CYC_RUN: begin
                s_d.cyc_cnt = s_q.cyc_cnt + CNT_W'(1);
                if (!s_q.root_en || subaction_gap_end || ov_hit) begin
                    s_d.cyc_st = CMEB_CYC_IDLE;
                end
            end
            default: begin
                s_d.cyc_st = CMEB_CYC_IDLE;
            end
        endcase
        // (RL13) overlong drops cycle master
        if (ov_hit) begin
            s_d.root_en = 1'b0;
        end
        // Read channel
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = rd_word[31:0];
            s_d.rresp = rd_word[32] ? RESP_SLVERR : RESP_OKAY;
        end
        s_d.arready = !s_d.rvalid;
        s_d.irq = |(s_d.evt & s_d.imask);
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            // (RL17) defined event reset
            s_q.evt <= EVT_RST;
            s_q.chan <= CHAN_RST;
            s_q.imask <= IMASK_RST;
            s_q.tmr <= TIMER_RST;
            s_q.cyc_st <= CMEB_CYC_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = s_q.awready;
    assign s_axi_wready = s_q.wready;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    // (RL1) mask drives receive enables
    assign rx_channel_enable = s_q.chan;
    assign timing_root_enable = s_q.root_en;
    assign late_ack_report_enable = s_q.late_en;
    assign irq = s_q.irq;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_chan_set;
        wr_go && s_q.aw_addr == OFF_CHAN_SET |=> ((s_q.chan & $past(wdat)) == $past(wdat));
    endproperty
    a_chan_set: assert property (p_chan_set) else $error("mask set lost"); // (RL2)

    property p_chan_clr;
        wr_go && s_q.aw_addr == OFF_CHAN_CLR |=> ((s_q.chan & $past(wdat)) == 32'h0);
    endproperty
    a_chan_clr: assert property (p_chan_clr) else $error("mask clear lost"); // (RL2)

    property p_chan_read;
        rd_go && (s_axi_araddr == OFF_CHAN_SET || s_axi_araddr == OFF_CHAN_CLR)
            |=> s_axi_rvalid && (s_axi_rdata == $past(s_q.chan));
    endproperty
    a_chan_read: assert property (p_chan_read) else $error("mask read wrong"); // (RL3)

    property p_evt_read;
        rd_go && s_axi_araddr == OFF_EVT_CLR
            |=> s_axi_rdata == $past(s_q.evt & s_q.imask);
    endproperty
    a_evt_read: assert property (p_evt_read) else $error("event read not masked"); // (RL6)

    property p_rsvd;
        !s_q.evt[EVT_RSVD_HI] && !s_q.evt[EVT_RSVD_LO] && s_q.evt[15:10] == 6'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved event bit set"); // (RL7)

    property p_no_hw_clear;
        1'b1 |=> (($past(s_q.evt) & ~$past(sw_clr) & ~s_q.evt) == 32'h0);
    endproperty
    a_no_hw_clear: assert property (p_no_hw_clear) else $error("event cleared"); // (RL5)

    property p_soft;
        sw_set[EVT_SOFT] |=> s_q.evt[EVT_SOFT];
    endproperty
    a_soft: assert property (p_soft) else $error("soft event not set"); // (RL9)

    property p_overlong;
        ov_hit |=> !timing_root_enable && s_q.evt[EVT_OVERLONG];
    endproperty
    a_overlong: assert property (p_overlong) else $error("overlong not handled"); // (RL13)

    property p_mismatch;
        mismatch && !s_q.src_prev[EVT_MISMATCH] && !s_q.evt[EVT_FATAL]
            |=> s_q.evt[EVT_MISMATCH];
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch missed"); // (RL16)

    property p_phy_byte;
        phy_byte_valid && !s_q.src_prev[EVT_PHY_BYTE] && !s_q.evt[EVT_FATAL]
            |=> s_q.evt[EVT_PHY_BYTE] && (s_q.phy_byte == $past(phy_byte));
    endproperty
    a_phy_byte: assert property (p_phy_byte) else $error("phy byte missed"); // (RL11)

    property p_block;
        s_q.evt[EVT_FATAL] && failed_ctx_events[EVT_PHY_BYTE]
            && !s_q.evt[EVT_PHY_BYTE] && !sw_set[EVT_PHY_BYTE] |=> !s_q.evt[EVT_PHY_BYTE];
    endproperty
    a_block: assert property (p_block) else $error("blocked event set"); // (RL15)

    property p_irq;
        irq == |(s_q.evt & s_q.imask);
    endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong"); // (RL6)

    c_overlong: cover property (ov_hit);
    c_evt_clear: cover property (wr_go && s_q.aw_addr == OFF_EVT_CLR ##1 !irq);
    c_gp_event: cover property (rise[EVT_GP] ##1 irq);
endmodule

// ===== src/cmeb_pkg.sv
/*
 * Constants for the channel mask and event bank: register offsets,
 * field positions, reset values, bus answers and timing figures.
 * Assumes an 8-bit byte address from an AXI4-Lite slave with 32-bit data.
 */
package cmeb_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_HCC_SET = 8'h50;
    localparam logic [7:0] OFF_HCC_CLR = 8'h54;
    localparam logic [7:0] OFF_CHAN_SET = 8'h78;
    localparam logic [7:0] OFF_CHAN_CLR = 8'h7c;
    localparam logic [7:0] OFF_EVT_SET = 8'h80;
    localparam logic [7:0] OFF_EVT_CLR = 8'h84;
    localparam logic [7:0] OFF_IMASK_SET = 8'h88;
    localparam logic [7:0] OFF_IMASK_CLR = 8'h8c;
    localparam logic [7:0] OFF_LCTL_SET = 8'he0;
    localparam logic [7:0] OFF_LCTL_CLR = 8'he4;
    localparam logic [7:0] OFF_PHYCTL = 8'hec;
    localparam logic [7:0] OFF_TIMER = 8'hf0;
    localparam logic [7:0] OFF_GPCTL = 8'hfc;

    // Event bit positions
    localparam int EVT_RSVD_HI = 31;
    localparam int EVT_GP = 30;
    localparam int EVT_SOFT = 29;
    localparam int EVT_RSVD_LO = 28;
    localparam int EVT_LATE_ACK = 27;
    localparam int EVT_PHY_BYTE = 26;
    localparam int EVT_OVERLONG = 25;
    localparam int EVT_FATAL = 24;
    localparam int EVT_MISMATCH = 23;
    // Event bits held by this bank; all others read as zero
    localparam logic [31:0] EVT_IMPL = 32'h6f80_0000;

    // Control field positions
    localparam int HCC_LATE_ACK_BIT = 29;
    localparam int LCTL_ROOT_BIT = 21;
    localparam int GP_UPPER_BIT = 31;
    localparam int GP_LOWER_BIT = 23;
    localparam int PHY_BYTE_LSB = 16;
    localparam int TMR_SEC_LSB = 25;
    localparam int TMR_CNT_LSB = 12;

    // Reset values
    localparam logic [31:0] CHAN_RST = 32'h0000_0000;
    localparam logic [31:0] EVT_RST = 32'h0000_0000;
    localparam logic [31:0] IMASK_RST = 32'h0000_0000;
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CYCLE_LIMIT_NS = 125000;
    localparam int CYCLE_LIMIT_CYC = CYCLE_LIMIT_NS / CLK_PERIOD_NS;

    // Overlong cycle watch states
    typedef enum logic [1:0] {
        CMEB_CYC_IDLE = 2'h1,
        CMEB_CYC_RUN = 2'h2
    } cmeb_cyc_t;
endpackage

// ===== tb/testbench.sv
/*
 * Self-checking bench for the channel mask and event bank.
 * Assumes cmeb_top with a short overlong-cycle limit.
 */
`timescale 1ns/1ps
module testbench;
    import cmeb_pkg::*;
    localparam int LIM = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, phy_byte = 8'h00, b;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, failed_ctx_events = 32'h0, d, cm, ev, mk, sel;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [31:0] s_axi_rdata, rx_channel_enable;
    logic gp_irq_upper_pin = 1'b0, gp_irq_lower_pin = 1'b0, rx_fifo_pending = 1'b0;
    logic phys_resp_busy = 1'b0, ack_tardy_sent = 1'b0, phy_byte_valid = 1'b0;
    logic cycle_start_tx = 1'b0, subaction_gap_end = 1'b0, subunit_dead = 1'b0;
    logic rx_cycle_start = 1'b0;
    logic [6:0] rx_seconds = 7'h00;
    logic [12:0] rx_count = 13'h0000;
    logic timing_root_enable, late_ack_report_enable, irq;
    integer seed = 32'hf068;
    int bad_count = 0;
    int checks = 0;
    int i;

    // Free-running clock
    always #10 clk = ~clk;

    cmeb_top #(.CYCLE_LIMIT(LIM), .CNT_W(16)) cmeb_top_i (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .gp_irq_upper_pin, .gp_irq_lower_pin,
        .rx_fifo_pending, .phys_resp_busy, .ack_tardy_sent, .phy_byte_valid, .phy_byte,
        .cycle_start_tx, .subaction_gap_end, .subunit_dead, .failed_ctx_events, .rx_cycle_start,
        .rx_seconds, .rx_count, .rx_channel_enable, .timing_root_enable,
        .late_ack_report_enable, .irq
    );

    // Verdict and end of run
    task automatic conclude();
        $display("Counts: checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        bad_count++;
        $display("MISMATCH t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
    endtask

    // Compare tasks, one per kind of result
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk_word({30'h0, got}, {30'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // AXI4-Lite write, aw and w offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_ok = 1'b0, w_ok = 1'b0, b_ok = 1'b0;
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        while (!b_ok && n < 50) begin
            @(posedge clk);
            n++;
            if (aw_ok && w_ok && s_axi_bvalid === 1'b1) begin
                b_ok = 1'b1;
                r = s_axi_bresp;
            end
            if (!aw_ok && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        if (!b_ok) hang();
    endtask

    // AXI4-Lite read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic ar_ok = 1'b0, r_ok = 1'b0;
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!r_ok && n < 50) begin
            @(posedge clk);
            n++;
            if (ar_ok && s_axi_rvalid === 1'b1) begin
                r_ok = 1'b1;
                v = s_axi_rdata;
                r = s_axi_rresp;
            end
            if (!ar_ok && s_axi_arready === 1'b1) begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
        end
        if (!r_ok) hang();
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] v);
        logic [1:0] r;
        wr(a, v, r);
        chk_resp(r, RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0] r;
        rd(a, v, r);
        chk_word(v, exp);
        chk_resp(r, RESP_OKAY);
    endtask

    // Event read plus interrupt line
    task automatic ev_chk(input logic [7:0] a, input logic [31:0] exp);
        rd_chk(a, exp);
        chk_bit(irq, |exp);
    endtask

    task automatic phy_pulse(input logic [7:0] v);
        phy_byte <= v;
        phy_byte_valid <= 1'b1;
        @(posedge clk);
        phy_byte_valid <= 1'b0;
        tick(3);
    endtask

    task automatic done(input string s);
        $display("Test %s finished, checks=%0d bad_count=%0d", s, checks, bad_count);
    endtask

    // Watchdog against a hang anywhere
    initial begin
        #1ms;
        hang();
    end

    // Main sequence
    initial begin
        tick(8);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(OFF_CHAN_SET, CHAN_RST);
        w(OFF_IMASK_SET, 32'hffff_ffff);
        ev_chk(OFF_EVT_SET, EVT_RST);
        done("reset");
        // Random set and clear of the channel mask
        cm = CHAN_RST;
        for (i = 0; i < 16; i++) begin
            d = (i == 0 || i == 15) ? 32'hffff_ffff : (i == 1) ? 32'h0 : $random(seed);
            sel = $random(seed);
            op = (sel[0] || i == 0) && i != 15;
            w(op ? OFF_CHAN_SET : OFF_CHAN_CLR, d);
            cm = op ? (cm | d) : (cm & ~d);
            rd_chk(sel[1] ? OFF_CHAN_CLR : OFF_CHAN_SET, cm);
            chk_word(rx_channel_enable, cm);
        end
        done("channel mask");
        // Software set and clear of events under a random mask
        ev = 32'h0;
        mk = 32'hffff_ffff;
        for (i = 0; i < 16; i++) begin
            d = (i == 0) ? 32'hffff_ffff : $random(seed);
            sel = $random(seed);
            op = sel[0] || i == 0;
            w(op ? OFF_EVT_SET : OFF_EVT_CLR, d);
            ev = op ? (ev | (d & EVT_IMPL)) : (ev & ~d);
            if (sel[2]) begin
                mk = $random(seed);
                w(OFF_IMASK_SET, mk);
                w(OFF_IMASK_CLR, ~mk);
            end
            ev_chk(sel[1] ? OFF_EVT_CLR : OFF_EVT_SET, ev & mk);
        end
        w(OFF_IMASK_SET, 32'hffff_ffff);
        w(OFF_EVT_SET, 32'h9000_0000);
        ev_chk(OFF_EVT_SET, ev);
        w(OFF_EVT_CLR, 32'hffff_ffff);
        w(OFF_EVT_SET, 32'h1 << EVT_SOFT);
        ev_chk(OFF_EVT_SET, 32'h1 << EVT_SOFT);
        w(OFF_EVT_CLR, 32'h1 << EVT_SOFT);
        done("software events");
        // General-purpose pins, disabled then enabled
        gp_irq_lower_pin <= 1'b1;
        tick(6);
        ev_chk(OFF_EVT_SET, 32'h0);
        gp_irq_lower_pin <= 1'b0;
        for (i = 0; i < 2; i++) begin
            w(OFF_GPCTL, 32'h1 << (i == 0 ? GP_LOWER_BIT : GP_UPPER_BIT));
            tick(6);
            {gp_irq_upper_pin, gp_irq_lower_pin} <= (i == 0) ? 2'h1 : 2'h2;
            tick(6);
            ev_chk(OFF_EVT_SET, 32'h1 << EVT_GP);
            tick(6);
            ev_chk(OFF_EVT_SET, 32'h1 << EVT_GP);
            w(OFF_EVT_CLR, 32'h1 << EVT_GP);
            {gp_irq_upper_pin, gp_irq_lower_pin} <= 2'h0;
            ev_chk(OFF_EVT_SET, 32'h0);
        end
        done("pins");
        // Late acknowledge sources
        rx_fifo_pending <= 1'b1;
        tick(4);
        rx_fifo_pending <= 1'b0;
        tick(2);
        ev_chk(OFF_EVT_SET, 32'h0);
        w(OFF_HCC_SET, 32'h1 << HCC_LATE_ACK_BIT);
        chk_bit(late_ack_report_enable, 1'b1);
        for (i = 0; i < 3; i++) begin
            {ack_tardy_sent, phys_resp_busy, rx_fifo_pending} <= 3'h1 << i;
            tick(3);
            {ack_tardy_sent, phys_resp_busy, rx_fifo_pending} <= 3'h0;
            tick(3);
            ev_chk(OFF_EVT_SET, 32'h1 << EVT_LATE_ACK);
            w(OFF_EVT_CLR, 32'h1 << EVT_LATE_ACK);
        end
        done("late ack");
        // PHY byte arrival
        b = $random(seed);
        phy_pulse(b);
        ev_chk(OFF_EVT_SET, 32'h1 << EVT_PHY_BYTE);
        rd(OFF_PHYCTL, d, rs);
        chk_word({24'h0, d[23:16]}, {24'h0, b});
        w(OFF_EVT_CLR, 32'h1 << EVT_PHY_BYTE);
        // Received cycle start: equal, seconds off, count off
        d = $random(seed);
        w(OFF_TIMER, d);
        for (i = 0; i < 3; i++) begin
            rx_seconds <= d[31:25] ^ {6'h0, i == 1};
            rx_count <= d[24:12] ^ {12'h0, i == 2};
            rx_cycle_start <= 1'b1;
            @(posedge clk);
            rx_cycle_start <= 1'b0;
            tick(3);
            ev_chk(OFF_EVT_SET, (i == 0) ? 32'h0 : 32'h1 << EVT_MISMATCH);
            w(OFF_EVT_CLR, 32'h1 << EVT_MISMATCH);
        end
        done("phy and timer");
        // Overlong cycle: one ended in time, one left running
        w(OFF_LCTL_SET, 32'h1 << LCTL_ROOT_BIT);
        chk_bit(timing_root_enable, 1'b1);
        for (i = 0; i < 2; i++) begin
            cycle_start_tx <= 1'b1;
            @(posedge clk);
            cycle_start_tx <= 1'b0;
            tick(5);
            subaction_gap_end <= (i == 0);
            @(posedge clk);
            subaction_gap_end <= 1'b0;
            tick(LIM - 9);
            chk_bit(timing_root_enable, 1'b1);
            tick(12);
            chk_bit(timing_root_enable, i == 0);
            ev_chk(OFF_EVT_SET, (i == 0) ? 32'h0 : 32'h1 << EVT_OVERLONG);
        end
        w(OFF_EVT_CLR, 32'hffff_ffff);
        done("overlong");
        // Fatal stop blocks the failed context's events
        failed_ctx_events <= 32'h1 << EVT_PHY_BYTE;
        subunit_dead <= 1'b1;
        tick(3);
        ev_chk(OFF_EVT_SET, 32'h1 << EVT_FATAL);
        phy_pulse($random(seed));
        ev_chk(OFF_EVT_SET, 32'h1 << EVT_FATAL);
        subunit_dead <= 1'b0;
        w(OFF_EVT_CLR, 32'h1 << EVT_FATAL);
        phy_pulse($random(seed));
        ev_chk(OFF_EVT_SET, 32'h1 << EVT_PHY_BYTE);
        done("fatal");
        // Unmapped address: error, no effect
        wr(8'h10, 32'hffff_ffff, rs);
        chk_resp(rs, RESP_SLVERR);
        rd(8'h10, d, rs);
        chk_resp(rs, RESP_SLVERR);
        chk_word(d, 32'h0);
        rd_chk(OFF_CHAN_CLR, cm);
        done("unmapped");
        conclude();
    end
endmodule
